// ===== mbft_consts.vh
`ifndef MBFT_CONSTS_VH
`define MBFT_CONSTS_VH

// System clock rate in MHz, used to turn microseconds into cycles.
`define MBFT_CLK_MHZ          20
// Link settings behind the RTU intervals: chars x bits x bit time x 1.01.
`define MBFT_BITS_PER_CHAR    11
`define MBFT_LINK_BAUD        19200
// Gap before a frame is suspected of breaking, 1.5 characters, in us.
`define MBFT_CHAR_GAP_US      868
// Full inter-frame silence, 3.5 characters, in us.
`define MBFT_FRAME_GAP_US     2026
// Remainder of the frame silence once the character gap has expired.
`define MBFT_FRAME_REST_US    (`MBFT_FRAME_GAP_US - `MBFT_CHAR_GAP_US)
// ASCII inter-character timeout in us.
`define MBFT_ASCII_GAP_US     1000000
// Period of the master's Read Coils poll in us.
`define MBFT_POLL_US          1000000
// Derived cycle counts at the system clock rate.
`define MBFT_CHAR_GAP_CYC     (`MBFT_CHAR_GAP_US * `MBFT_CLK_MHZ)
`define MBFT_FRAME_REST_CYC   (`MBFT_FRAME_REST_US * `MBFT_CLK_MHZ)
`define MBFT_ASCII_GAP_CYC    (`MBFT_ASCII_GAP_US * `MBFT_CLK_MHZ)
`define MBFT_POLL_CYC         (`MBFT_POLL_US * `MBFT_CLK_MHZ)
// Width of the timer counters; holds the one second count.
`define MBFT_TMR_W            25
// Receive buffer depth in bytes.
`define MBFT_RX_BUF_DEPTH     8'd253
// Poll target and function code.
`define MBFT_POLL_SLAVE       8'h01
`define MBFT_FC_READ_COILS    8'h01
// Supported function codes in slave mode.
`define MBFT_FC_READ_DI       8'h02
`define MBFT_FC_READ_HR       8'h03
`define MBFT_FC_READ_IR       8'h04
`define MBFT_FC_WRITE_COIL    8'h05
`define MBFT_FC_WRITE_REG     8'h06
`define MBFT_FC_WRITE_COILS   8'h0F
`define MBFT_FC_WRITE_REGS    8'h10
`define MBFT_FC_RW_REGS       8'h17
// ASCII framing characters.
`define MBFT_CHAR_COLON       8'h3A
`define MBFT_CHAR_CR          8'h0D
`define MBFT_CHAR_LF          8'h0A
// CRC-16 parameters, reflected form.
`define MBFT_CRC_INIT         16'hFFFF
`define MBFT_CRC_POLY         16'hA001
// Shortest legal frame in bytes: address, function and check.
`define MBFT_MIN_LEN_RTU      8'd4
`define MBFT_MIN_LEN_ASCII    8'd3
// Error codes reported on reject and in the log.
`define MBFT_ERR_NOT_MINE     8'h03
`define MBFT_ERR_FUNCTION     8'h04
`define MBFT_ERR_CHECKSUM     8'h05
`define MBFT_ERR_CHAR_GAP     8'h06
`define MBFT_ERR_LENGTH       8'h07

`endif

// ===== mbft_interval_timer.v
`timescale 1ns/1ps
// Loadable one-shot down counter; the expiry pulse comes period cycles after load.
module mbft_interval_timer #(
    parameter W = 25
) (
    // Clock and reset.
    input  wire         sys_clk,
    input  wire         rst_b,
    // Control.
    input  wire         load,
    input  wire [W-1:0] loadValue,
    input  wire         stop,
    // Status.
    output reg          expired,
    output reg          running
);

    reg [W-1:0] count_reg;  // Cycles left until expiry.

    // Load wins over stop; the count ends with a one-cycle expiry pulse.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            count_reg <= {W{1'b0}};
            expired   <= 1'b0;
            running   <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                count_reg <= loadValue;
                running   <= 1'b1;
            end else if (stop) begin
                running <= 1'b0;
            end else if (running) begin
                if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
                    expired <= 1'b1;
                    running <= 1'b0;
                end else begin
                    count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // mbft_interval_timer

// ===== mbft_frame_timing.v
`timescale 1ns/1ps
`include "mbft_consts.vh"

// Contract
// - Pass frame only if address, function, checksum good
// - ASCII gap expiry mid-frame: error, clear buffer
// - ASCII gap one second, adjustable longer
// - RTU gap expiry: set pending flag, reload
// - RTU character while pending: error, clear buffer
// - RTU reload expiry while pending: frame received
// - RTU gaps of 1.5 and 3.5 characters
// - Intervals from 11 bits, 19200 baud, 1%
// - Character gap 868 us, frame 2026 us
// - One gap timer, reloaded with 1158 us
// - Master polls slave 1 with Read Coils each second
// - Poll timer separate from gap timer
// - Master hands slave response to application
// - Copy frames and errors to log port
// - Read Coils uses function code 0x01
module mbft_frame_timing #(
    parameter            TMR_W          = `MBFT_TMR_W,
    parameter [TMR_W-1:0] CHAR_GAP_CYC  = `MBFT_CHAR_GAP_CYC,
    parameter [TMR_W-1:0] FRAME_REST_CYC = `MBFT_FRAME_REST_CYC,
    parameter [TMR_W-1:0] ASCII_GAP_CYC = `MBFT_ASCII_GAP_CYC,
    parameter [TMR_W-1:0] POLL_CYC      = `MBFT_POLL_CYC,
    parameter [7:0]      BUF_DEPTH      = `MBFT_RX_BUF_DEPTH
) (
    // Clock and reset.
    input  wire       sys_clk,
    input  wire       rst_b,
    // Static configuration.
    input  wire       rtuMode,
    input  wire       masterMode,
    input  wire [7:0] ownAddress,
    // Characters from the link receiver.
    input  wire       rxValid,
    input  wire [7:0] rxData,
    // Application handler side.
    input  wire [7:0] appReadIndex,
    output reg  [7:0] appReadByte,
    output reg        appFrameValid,
    output reg        appFrameReject,
    output reg  [7:0] appFrameLength,
    output reg  [7:0] appRejectCode,
    // Poll request to the link transmitter.
    output reg        pollSend,
    output reg  [7:0] pollSlaveAddr,
    output reg  [7:0] pollFunction,
    // Log port feed.
    output reg        logValid,
    output reg        logIsError,
    output reg  [7:0] logByte
);

    reg  [7:0]       rxBuf [0:BUF_DEPTH-1];  // Decoded frame bytes.
    reg  [7:0]       rxCount_reg;            // Bytes stored in the frame.
    reg  [15:0]      crc_reg;                // Running CRC over the frame.
    reg  [7:0]       lrc_reg;                // Running byte sum over the frame.
    reg  [7:0]       addr_reg;               // First frame byte.
    reg  [7:0]       func_reg;               // Second frame byte.
    reg              overflow_reg;           // Frame longer than the buffer.
    reg              badChar_reg;            // Illegal ASCII character seen.
    reg              inFrame_reg;            // A character arrived, frame open.
    reg              pendingGap_reg;         // RTU character gap has expired.
    reg              half_reg;               // High nibble held, ASCII.
    reg  [3:0]       hiNib_reg;              // Held high nibble.
    reg              sawCr_reg;              // Last ASCII character was CR.
    reg              frameDone_reg;          // Frame ended, check next cycle.
    reg              isHex;                  // Incoming character is a hex digit.
    reg  [3:0]       hexVal;                 // Its value.
    reg              checkOk;                // All acceptance checks pass.
    reg  [7:0]       checkCode;              // First failing check.
    wire             gapExpired;             // Gap timer expiry pulse.
    wire             pollExpired;            // Poll timer expiry pulse.
    wire             pollRunning;            // Poll timer counting.
    integer          k;

    // CRC-16 update by one byte, reflected polynomial.
    function [15:0] crcStep;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] t;
        begin
            t = c ^ {8'h00, d};
            for (i = 0; i < 8; i = i + 1) begin
                t = t[0] ? ((t >> 1) ^ `MBFT_CRC_POLY) : (t >> 1);
            end
            crcStep = t;
        end
    endfunction

    // Hex digit decode of the incoming character, both letter cases.
    always @* begin
        isHex  = 1'b0;
        hexVal = rxData[3:0];
        if (rxData >= 8'h30 && rxData <= 8'h39) begin
            isHex = 1'b1;
        end else if ((rxData >= 8'h41 && rxData <= 8'h46) ||
                     (rxData >= 8'h61 && rxData <= 8'h66)) begin
            isHex  = 1'b1;
            hexVal = rxData[3:0] + 4'h9;
        end
    end

    // Event decode for both framing forms.
    wire asciiRx    = !rtuMode && rxValid;
    wire asciiStart = asciiRx && (rxData == `MBFT_CHAR_COLON);
    wire asciiBody  = asciiRx && inFrame_reg && !asciiStart;
    wire asciiPush  = asciiBody && isHex && half_reg;
    wire asciiEnd   = asciiBody && (rxData == `MBFT_CHAR_LF) && sawCr_reg;
    wire asciiErr   = !rtuMode && gapExpired && inFrame_reg && !rxValid;
    wire rtuErr     = rtuMode && rxValid && pendingGap_reg;
    wire rtuPush    = rtuMode && rxValid && !pendingGap_reg;
    wire rtuPend    = rtuMode && gapExpired && inFrame_reg && !pendingGap_reg
                      && !rxValid;
    wire rtuEnd     = rtuMode && gapExpired && pendingGap_reg && !rxValid;
    wire gapErr     = asciiErr || rtuErr;
    wire frameEnd   = asciiEnd || rtuEnd;
    wire pushByte   = rtuPush || asciiPush;
    wire [7:0] pushData = rtuMode ? rxData : {hiNib_reg, hexVal};
    // An RTU character outside a frame opens a fresh one.
    wire       fresh    = rtuMode && !inFrame_reg;
    wire [7:0] curCount = fresh ? 8'h00 : rxCount_reg;
    wire [15:0] curCrc  = fresh ? `MBFT_CRC_INIT : crc_reg;
    wire [7:0] curLrc   = fresh ? 8'h00 : lrc_reg;

    // Gap timer control: each frame character but a pending-gap RTU one or the closing LF restarts it, the pending step reloads it.
    wire gapLoad = rtuPush || asciiStart || (asciiBody && !asciiEnd) || rtuPend;
    wire [TMR_W-1:0] gapValue = rtuPend ? FRAME_REST_CYC :
                                (rtuMode ? CHAR_GAP_CYC : ASCII_GAP_CYC);
    wire gapStop = gapErr || frameEnd;

    // The single gap timer serves both the character and the frame gap.
    mbft_interval_timer #(.W(TMR_W)) gapTimer (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .load      (gapLoad),
        .loadValue (gapValue),
        .stop      (gapStop),
        .expired   (gapExpired),
        .running   ()
    );

    // A separate timer paces the master's poll and reloads itself.
    mbft_interval_timer #(.W(TMR_W)) pollTimer (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .load      (masterMode && (pollExpired || !pollRunning)),
        .loadValue (POLL_CYC),
        .stop      (!masterMode),
        .expired   (pollExpired),
        .running   (pollRunning)
    );

    // Frame assembly, gap tracking and buffer clearing on character errors.
    always @(posedge sys_clk) begin
        // Reset and gap errors wipe the bytes; a push never falls on a gap error.
        if (!rst_b || gapErr) begin
            for (k = 0; k < BUF_DEPTH; k = k + 1) begin
                rxBuf[k] <= 8'h00;
            end
        end
        if (!rst_b) begin
            rxCount_reg    <= 8'h00;
            crc_reg        <= `MBFT_CRC_INIT;
            lrc_reg        <= 8'h00;
            addr_reg       <= 8'h00;
            func_reg       <= 8'h00;
            overflow_reg   <= 1'b0;
            badChar_reg    <= 1'b0;
            inFrame_reg    <= 1'b0;
            pendingGap_reg <= 1'b0;
            half_reg       <= 1'b0;
            hiNib_reg      <= 4'h0;
            sawCr_reg      <= 1'b0;
            frameDone_reg  <= 1'b0;
        end else begin
            frameDone_reg <= frameEnd;
            if (gapErr) begin
                // Discard the count and wipe the stored bytes.
                rxCount_reg    <= 8'h00;
                inFrame_reg    <= 1'b0;
                pendingGap_reg <= 1'b0;
                half_reg       <= 1'b0;
                sawCr_reg      <= 1'b0;
            end else if (asciiStart) begin
                // A colon always opens a new ASCII frame.
                rxCount_reg  <= 8'h00;
                lrc_reg      <= 8'h00;
                overflow_reg <= 1'b0;
                badChar_reg  <= 1'b0;
                inFrame_reg  <= 1'b1;
                half_reg     <= 1'b0;
                sawCr_reg    <= 1'b0;
            end else begin
                if (pushByte) begin
                    // Store the byte and fold it into both check sums.
                    if (curCount < BUF_DEPTH) begin
                        rxBuf[curCount] <= pushData;
                        rxCount_reg     <= curCount + 8'h01;
                        overflow_reg    <= fresh ? 1'b0 : overflow_reg;
                    end else begin
                        overflow_reg <= 1'b1;
                    end
                    if (fresh) begin
                        badChar_reg <= 1'b0;
                    end
                    crc_reg <= crcStep(curCrc, pushData);
                    lrc_reg <= curLrc + pushData;
                    if (curCount == 8'h00) begin
                        addr_reg <= pushData;
                    end
                    if (curCount == 8'h01) begin
                        func_reg <= pushData;
                    end
                end
                if (rtuPush) begin
                    inFrame_reg <= 1'b1;
                end
                if (rtuPend) begin
                    pendingGap_reg <= 1'b1;
                end
                if (frameEnd) begin
                    inFrame_reg    <= 1'b0;
                    pendingGap_reg <= 1'b0;
                end
                if (asciiBody) begin
                    // Pair nibbles into bytes and watch for the CR LF ending.
                    sawCr_reg <= (rxData == `MBFT_CHAR_CR);
                    if (isHex) begin
                        half_reg  <= !half_reg;
                        hiNib_reg <= hexVal;
                    end else if (rxData != `MBFT_CHAR_CR && !asciiEnd) begin
                        badChar_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // Acceptance checks in the order length, address, function, checksum.
    always @* begin
        checkOk   = 1'b0;
        checkCode = 8'h00;
        if (overflow_reg || badChar_reg || half_reg ||
            rxCount_reg < (rtuMode ? `MBFT_MIN_LEN_RTU : `MBFT_MIN_LEN_ASCII)) begin
            checkCode = `MBFT_ERR_LENGTH;
        end else if (addr_reg != (masterMode ? `MBFT_POLL_SLAVE : ownAddress)) begin
            checkCode = `MBFT_ERR_NOT_MINE;
        end else if (masterMode ? (func_reg != `MBFT_FC_READ_COILS) :
                     !(func_reg == `MBFT_FC_READ_COILS || func_reg == `MBFT_FC_READ_DI ||
                       func_reg == `MBFT_FC_READ_HR || func_reg == `MBFT_FC_READ_IR ||
                       func_reg == `MBFT_FC_WRITE_COIL || func_reg == `MBFT_FC_WRITE_REG ||
                       func_reg == `MBFT_FC_WRITE_COILS ||
                       func_reg == `MBFT_FC_WRITE_REGS || func_reg == `MBFT_FC_RW_REGS)) begin
            checkCode = `MBFT_ERR_FUNCTION;
        end else if (rtuMode ? (crc_reg != 16'h0000) : (lrc_reg != 8'h00)) begin
            checkCode = `MBFT_ERR_CHECKSUM;
        end else begin
            checkOk = 1'b1;
        end
    end

    // Hand accepted frames to the application, report rejects, poll and log.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            appReadByte    <= 8'h00;
            appFrameValid  <= 1'b0;
            appFrameReject <= 1'b0;
            appFrameLength <= 8'h00;
            appRejectCode  <= 8'h00;
            pollSend       <= 1'b0;
            pollSlaveAddr  <= 8'h00;
            pollFunction   <= 8'h00;
            logValid       <= 1'b0;
            logIsError     <= 1'b0;
            logByte        <= 8'h00;
        end else begin
            appReadByte    <= (appReadIndex < BUF_DEPTH) ? rxBuf[appReadIndex] : 8'h00;
            appFrameValid  <= frameDone_reg && checkOk;
            appFrameReject <= frameDone_reg && !checkOk;
            if (frameDone_reg) begin
                appFrameLength <= rxCount_reg;
                appRejectCode  <= checkCode;
            end
            pollSend <= masterMode && pollExpired;
            if (masterMode && pollExpired) begin
                pollSlaveAddr <= `MBFT_POLL_SLAVE;
                pollFunction  <= `MBFT_FC_READ_COILS;
            end
            // Errors take the log slot before plain received characters.
            logValid   <= (frameDone_reg && !checkOk) || gapErr || rxValid;
            logIsError <= (frameDone_reg && !checkOk) || gapErr;
            if (frameDone_reg && !checkOk) begin
                logByte <= checkCode;
            end else if (gapErr) begin
                logByte <= `MBFT_ERR_CHAR_GAP;
            end else if (rxValid) begin
                logByte <= rxData;
            end
        end
    end

endmodule // mbft_frame_timing

// ===== mbft_frame_timing_monitor.sv
`timescale 1ns/1ps
// Ties frame ends, logs and polls to their causes.
module mbft_frame_timing_monitor #(
    parameter             TMR_W          = 25,
    parameter [TMR_W-1:0] CHAR_GAP_CYC   = 40,
    parameter [TMR_W-1:0] FRAME_REST_CYC = 54,
    parameter [TMR_W-1:0] POLL_CYC       = 2000
) (
    // Clock and reset.
    input wire       sys_clk,
    input wire       rst_b,
    // Configuration and receiver.
    input wire       rtuMode,
    input wire       masterMode,
    input wire       rxValid,
    input wire [7:0] rxData,
    // Application side.
    input wire       appFrameValid,
    input wire       appFrameReject,
    input wire [7:0] appRejectCode,
    // Poll and log.
    input wire       pollSend,
    input wire [7:0] pollSlaveAddr,
    input wire [7:0] pollFunction,
    input wire       logValid,
    input wire       logIsError,
    input wire [7:0] logByte
);
    // Expiry windows, with slack for load latency.
    localparam int SUM     = CHAR_GAP_CYC + FRAME_REST_CYC;
    localparam int END_LO  = SUM - 2;
    localparam int END_HI  = SUM + 6;
    localparam int PEND_LO = CHAR_GAP_CYC + 3;
    localparam int PEND_HI = SUM - 3;
    localparam int QUICK   = CHAR_GAP_CYC - 3;
    logic [31:0] sinceChar; // Cycles since the last taken character, saturating.
    logic [31:0] sincePoll; // Cycles since the last poll pulse.
    logic        pollSeen;  // A first poll has been seen since reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Counts receiver silence to place expiries in time.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            sinceChar <= 32'h0000FFFF;
        end else if (rxValid) begin
            sinceChar <= 32'h00000001;
        end else if (sinceChar < 32'h0000FFFF) begin
            sinceChar <= sinceChar + 32'h00000001;
        end
    end
    // Counts the spacing between poll pulses.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            sincePoll <= 32'h00000000;
            pollSeen  <= 1'b0;
        end else begin
            sincePoll <= pollSend ? 32'h00000001 : sincePoll + 32'h00000001;
            pollSeen  <= pollSeen | pollSend;
        end
    end
    // A character that lands while the frame gap is pending.
    sequence s_pending_char;
        rtuMode && rxValid && sinceChar >= PEND_LO && sinceChar <= PEND_HI;
    endsequence
    // The log entry for a character gap fault.
    sequence s_gap_error_log;
        logValid && logIsError && logByte == 8'h06;
    endsequence
    property p_pending_error;
        s_pending_char |=> s_gap_error_log;
    endproperty
    a_end_exclusive: assert property (!(appFrameValid && appFrameReject))
        else $error("frame both accepted and rejected");
    a_accept_code: assert property (appFrameValid |-> appRejectCode == 8'h00)
        else $error("accepted frame carries a reject code");
    a_reject_code: assert property (appFrameReject |-> appRejectCode inside {8'h03, 8'h04, 8'h05, 8'h07})
        else $error("rejected frame has no valid code");
    a_log_every_char: assert property (rxValid |=> logValid)
        else $error("character not followed by a log entry");
    a_log_echo_byte: assert property (logValid && !logIsError |-> $past(rxValid) && logByte == $past(rxData))
        else $error("log byte differs from received character");
    a_rtu_end_time: assert property (rtuMode && (appFrameValid || appFrameReject) |-> sinceChar >= END_LO && sinceChar <= END_HI)
        else $error("frame end not at the full frame silence");
    a_pending_error: assert property (p_pending_error)
        else $error("character during pending gap not flagged");
    a_quick_char_ok: assert property (rtuMode && rxValid && sinceChar <= QUICK |=> logValid && !logIsError)
        else $error("closely spaced character flagged as gap fault");
    a_poll_period: assert property (pollSend && pollSeen |-> sincePoll == POLL_CYC + 1)
        else $error("poll spacing wrong");
    a_poll_fields: assert property (pollSend |=> pollSlaveAddr == 8'h01 && pollFunction == 8'h01)
        else $error("poll address or function wrong");
    a_slave_quiet: assert property (!masterMode && !$past(masterMode) |-> !pollSend)
        else $error("poll sent in slave mode");
endmodule // mbft_frame_timing_monitor

bind mbft_frame_timing mbft_frame_timing_monitor #(.TMR_W(TMR_W),
    .CHAR_GAP_CYC(CHAR_GAP_CYC), .FRAME_REST_CYC(FRAME_REST_CYC), .POLL_CYC(POLL_CYC)
) u_mon (.*);

// ===== mbft_link_partner.sv
`timescale 1ns/1ps
// Far end of the link as seen through the receiver: one character per pulse.
module mbft_link_partner (
    // Clock.
    input  wire       sys_clk,
    // Character stream.
    output logic       rxValid,
    output logic [7:0] rxData
);
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
    end
    // One character, then gap idle cycles; data inverted so stale is never new.
    task automatic sendChar(input logic [7:0] d, input int gap);
        @(posedge sys_clk);
        rxValid <= 1'b1;
        rxData  <= d;
        @(posedge sys_clk);
        rxValid <= 1'b0;
        rxData  <= ~d;
        repeat (gap) @(posedge sys_clk);
    endtask
endmodule // mbft_link_partner

// ===== test_mbft_frame_timing.sv
`timescale 1ns/1ps
// Self-checking bench for the frame timing and acceptance block.
module test_mbft_frame_timing;
    localparam int NG = 40;   // Shortened character gap.
    localparam int NR = 54;   // Shortened frame remainder.
    localparam int NA = 200;  // Shortened ASCII gap.
    localparam int NP = 2000; // Shortened poll period.
    // Inputs driven by the bench.
    logic       sys_clk      = 1'b0;
    logic       rst_b        = 1'b0;
    logic       rtuMode      = 1'b1;
    logic       masterMode   = 1'b0;
    logic [7:0] ownAddress   = 8'h11;
    logic [7:0] appReadIndex = 8'h00;
    // Receiver stream from the partner and design outputs.
    wire        rxValid, appFrameValid, appFrameReject, pollSend, logValid, logIsError;
    wire  [7:0] rxData, appReadByte, appFrameLength, appRejectCode;
    wire  [7:0] pollSlaveAddr, pollFunction, logByte;
    // Bookkeeping.
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles     = 0;
    int         errCnt     = 0;
    logic [7:0] lastErr;
    always #25 sys_clk = ~sys_clk;
    mbft_frame_timing #(.CHAR_GAP_CYC(NG), .FRAME_REST_CYC(NR), .ASCII_GAP_CYC(NA),
        .POLL_CYC(NP)) u_dut (.*);
    mbft_link_partner u_partner (.sys_clk(sys_clk), .rxValid(rxValid), .rxData(rxData));
    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    // Remembers error entries on the log feed.
    always @(posedge sys_clk) begin
        if (logValid === 1'b1 && logIsError === 1'b1) begin
            errCnt  = errCnt + 1;
            lastErr = logByte;
        end
    end
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Compares a byte result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Compares a flag result.
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Holds reset for six cycles.
    task automatic doReset();
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask
    // Waits a bounded time for a frame end pulse.
    task automatic waitEnd(output logic v, output logic r);
        v = 1'b0;
        r = 1'b0;
        for (int i = 0; i < 400 && !(v || r); i++) begin
            @(posedge sys_clk);
            #1;
            v = (appFrameValid === 1'b1);
            r = (appFrameReject === 1'b1);
        end
    endtask
    // Reflected CRC-16 over a byte list.
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    // ASCII character of one nibble.
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction
    // Sends an eight byte RTU frame, checks verdict; bad breaks CRC.
    task automatic rtuCase(input logic [7:0] a, f, input logic bad, input logic [7:0] code);
        logic [7:0]  b[$];
        logic [15:0] c;
        logic        v, r;
        b = '{a, f, 8'h00, 8'h00, 8'h00, 8'h01};
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) u_partner.sendChar(b[i], 3);
        waitEnd(v, r);
        chk1(v, code == 8'h00);
        chk1(r, code != 8'h00);
        chk8(appRejectCode, code);
        chk8(appFrameLength, 8'h08);
        repeat (5) @(posedge sys_clk);
    endtask
    // Slave RTU: every supported function, then one address, one function and one checksum fault.
    task automatic testRtuSlave();
        logic [7:0] fcs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17};
        foreach (fcs[i]) rtuCase(8'h11, fcs[i], 1'b0, 8'h00);
        @(posedge sys_clk) appReadIndex <= 8'h01;
        repeat (2) @(posedge sys_clk);
        #1;
        chk8(appReadByte, 8'h17);
        rtuCase(8'h12, 8'h03, 1'b0, 8'h03);
        rtuCase(8'h11, 8'h07, 1'b0, 8'h04);
        rtuCase(8'h11, 8'h03, 1'b1, 8'h05);
    endtask
    // Slave RTU: a character in the pending gap is a fault, then recovery.
    task automatic testRtuGap();
        errCnt = 0;
        u_partner.sendChar(8'h11, 3);
        u_partner.sendChar(8'h03, NG + 10);
        u_partner.sendChar(8'h03, 3);
        repeat (3) @(posedge sys_clk);
        chk8(lastErr, 8'h06);
        chk1(errCnt == 1, 1'b1);
        repeat (200) @(posedge sys_clk);
        rtuCase(8'h11, 8'h03, 1'b0, 8'h00);
    endtask
    // Slave ASCII: a slow but in-time frame, then a stalled one.
    task automatic testAscii();
        logic [7:0] b [7] = '{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'hEB};
        logic       v, r;
        @(posedge sys_clk) rtuMode <= 1'b0;
        u_partner.sendChar(8'h3A, NA - 20);
        foreach (b[i]) begin
            u_partner.sendChar(hexc(b[i][7:4]), NA - 20);
            u_partner.sendChar(hexc(b[i][3:0]), NA - 20);
        end
        u_partner.sendChar(8'h0D, 3);
        u_partner.sendChar(8'h0A, 0);
        waitEnd(v, r);
        chk1(v, 1'b1);
        chk8(appFrameLength, 8'h07);
        errCnt = 0;
        u_partner.sendChar(8'h3A, 3);
        u_partner.sendChar(8'h31, NA + 30);
        chk8(lastErr, 8'h06);
        chk1(errCnt == 1, 1'b1);
    endtask
    // Master RTU: poll spacing and fields, then replies from two slaves.
    task automatic testMaster();
        int t;
        @(posedge sys_clk) masterMode <= 1'b1;
        rtuMode <= 1'b1;
        doReset();
        for (t = 0; t < NP + 10 && pollSend !== 1'b1; t++) @(posedge sys_clk) #1;
        t = 0;
        do begin
            @(posedge sys_clk) #1;
            t++;
        end while (pollSend !== 1'b1 && t < NP + 10);
        chk1(t == NP + 1, 1'b1);
        @(posedge sys_clk) #1;
        chk8(pollSlaveAddr, 8'h01);
        chk8(pollFunction, 8'h01);
        rtuCase(8'h01, 8'h01, 1'b0, 8'h00);
        rtuCase(8'h02, 8'h01, 1'b0, 8'h03);
    endtask
    // Main sequence.
    initial begin
        doReset();
        testRtuSlave();
        testRtuGap();
        testAscii();
        testMaster();
        stop_test();
    end
endmodule // test_mbft_frame_timing
